/* src/fps_cfg.svh */
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH
`define FPS_AW 8
`define FPS_NWORDS 31
`define FPS_LAST_WORD 5'h1E
`define FPS_LAST_BIT 10'h3DF
`define FPS_OFF_KEY 8'h80
`define FPS_OFF_CMD 8'h84
`define FPS_OFF_TIME 8'h88
`define FPS_OFF_CP 8'h8C
`define FPS_OFF_RAW 8'h90
`define FPS_OFF_ENA 8'h94
`define FPS_OFF_ST 8'h98
`define FPS_OFF_CLR 8'h9C
`define FPS_OFF_CODE 8'hA0
`define FPS_KEY_PGM 16'h5A5A
`define FPS_KEY_RD 16'h5AA5
`define FPS_CMD_IDLE 2'h0
`define FPS_CMD_RD 2'h1
`define FPS_CMD_PGM 2'h2
`define FPS_EV_RD 0
`define FPS_EV_PGM 1
`define FPS_W_WRDIS 5'h00
`define FPS_W_HOLD 5'h03
`define FPS_B_HOLD 14
`define FPS_W_CODE 5'h06
`define FPS_W_KEY1 5'h07
`define FPS_W_KEY2 5'h0F
`define FPS_W_KEY3 5'h17
`define FPS_W_RSV_LO 5'h1B
`define FPS_W_RSV_HI 5'h1C
`define FPS_WP_BLK0 4'h0
`define FPS_WP_KEY1 4'h7
`define FPS_WP_KEY2 4'h8
`define FPS_WP_KEY3 4'h9
`define FPS_CODE_NONE 2'h0
`define FPS_CODE_34 2'h1
`define FPS_CODE_REP 2'h2
`define FPS_WID_NONE 9'h100
`define FPS_WID_34 9'h0C0
`define FPS_WID_REP 9'h080
`endif

/* src/fps_pkg.sv */
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_IDLE, FPS_P_SCAN, FPS_P_PULSE, FPS_P_GAP,
    FPS_R_ISSUE, FPS_R_HOLD, FPS_R_CAP
  } fps_state_t;
  typedef struct packed {
    logic pgm;
    logic rd;
    logic [9:0] addr;
  } fps_fuse_req_t;
endpackage

/* src/fps_pulse_timer.sv */
`timescale 1ns/10ps
// Counts a software-given number of cycles; zero acts as one cycle
module fps_pulse_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] count,
  output logic expire
);
  logic [7:0] cnt_q;
  logic busy_q;

  assign expire = busy_q && (cnt_q <= 8'h01);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= count;
      busy_q <= 1'b1;
    end
    else if (expire)
      busy_q <= 1'b0;
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule // fps_pulse_timer

/* src/fps_top.sv */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "fps_cfg.svh"
// Notes on behaviour
// - Hold parameter 0: coding select and key blocks take any value.
// - Hold parameter 1: force 3/4 coding; key three words four, five unusable.
// - Each parameter bit maps to one program-data bit; key block eight words.
// - Key 0x5A5A then command 0x2 starts a burn.
// - Burn end: command back to 0x0, program-done event raised.
// - Key 0x5AA5 then command 0x1 reloads fuse contents.
// - Reload end: command back to 0x0, read-done event raised.
// - Raw events: bit 1 program-done, bit 0 read-done, enable ignored.
// - Writing 1 to clear bits 1 or 0 clears that event.
// - Event reaches interrupt only when its enable bit is 1.
// - Status shows events both raised and enabled.
// - Bits and parameters may be burned over separate operations.
// - Burn only moves unburned bits 0 to 1; ones stay.
// - Parameter with protect bit 1 is never burned.
// - Coding 00/11 none 256, 01 3/4 192, 10 repeat 128.
module fps_top (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output fps_pkg::fps_fuse_req_t FUSE_REQ,
  input wire logic [31:0] FUSE_RDATA,
  output logic [7:0] FUSE_PUMP_DIV,
  output logic IRQ
);
  logic [31:0] prog_q [`FPS_NWORDS];
  logic [31:0] shadow_q [`FPS_NWORDS];
  logic [31:0] rdata_q;
  logic [15:0] key_q;
  logic [7:0] sel_a_q, sel_b_q, pump_q, tmr_count;
  logic [1:0] cmd_q, raw_q, raw_d, ena_q, code_eff;
  logic irq_q, tmr_load, tmr_expire, wr_cmd, start_pgm, start_rd;
  logic pgm_fin, rd_fin, hold, burn_here;
  fps_pkg::fps_state_t state_q;
  fps_pkg::fps_fuse_req_t req_q;
  logic [9:0] idx_q;
  logic [4:0] rword_q;
  default clocking cb_sys @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // Write-protect bit guarding a program-data word
  function automatic logic [3:0] guard_bit(input logic [4:0] w);
    if (w >= `FPS_W_KEY3)
      guard_bit = `FPS_WP_KEY3;
    else if (w >= `FPS_W_KEY2)
      guard_bit = `FPS_WP_KEY2;
    else if (w >= `FPS_W_KEY1)
      guard_bit = `FPS_WP_KEY1;
    else
      guard_bit = `FPS_WP_BLK0;
  endfunction
  function automatic logic reserved(input logic [4:0] w, input logic h);
    reserved = h && (w >= `FPS_W_RSV_LO) && (w <= `FPS_W_RSV_HI);
  endfunction
  function automatic logic [8:0] scheme_width(input logic [1:0] c);
    unique case (c)
      `FPS_CODE_34: scheme_width = `FPS_WID_34;
      `FPS_CODE_REP: scheme_width = `FPS_WID_REP;
      default: scheme_width = `FPS_WID_NONE;
    endcase
  endfunction
  assign hold = shadow_q[`FPS_W_HOLD][`FPS_B_HOLD];
  // Forced 3/4 under hold, else the burned select as is
  assign code_eff = hold ? `FPS_CODE_34 : shadow_q[`FPS_W_CODE][1:0];
  assign burn_here = prog_q[idx_q[9:5]][idx_q[4:0]]
    && !shadow_q[idx_q[9:5]][idx_q[4:0]]
    && !shadow_q[`FPS_W_WRDIS][guard_bit(idx_q[9:5])]
    && !reserved(idx_q[9:5], hold);
  assign wr_cmd = REG_WR && (REG_ADDR == `FPS_OFF_CMD);
  assign start_pgm = wr_cmd && (state_q == fps_pkg::FPS_IDLE)
    && (REG_WDATA[1:0] == `FPS_CMD_PGM) && (REG_WDATA[31:2] == 30'h0)
    && (key_q == `FPS_KEY_PGM);
  assign start_rd = wr_cmd && (state_q == fps_pkg::FPS_IDLE)
    && (REG_WDATA[1:0] == `FPS_CMD_RD) && (REG_WDATA[31:2] == 30'h0)
    && (key_q == `FPS_KEY_RD);
  assign pgm_fin = (idx_q == `FPS_LAST_BIT)
    && (((state_q == fps_pkg::FPS_P_SCAN) && !burn_here)
    || ((state_q == fps_pkg::FPS_P_GAP) && tmr_expire));
  assign rd_fin = (state_q == fps_pkg::FPS_R_CAP)
    && (rword_q == `FPS_LAST_WORD);
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_count = sel_a_q;
    if ((state_q == fps_pkg::FPS_P_SCAN) && burn_here)
      tmr_load = 1'b1;
    else if ((state_q == fps_pkg::FPS_P_PULSE) && tmr_expire)
    begin
      tmr_load = 1'b1;
      tmr_count = sel_b_q;
    end
  end
  fps_pulse_timer u_timer (
    .clk(CLK_SYS),
    .nrst(NRST),
    .load(tmr_load),
    .count(tmr_count),
    .expire(tmr_expire)
  );
  // Program-data words, one flip-flop word per bus word
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < `FPS_NWORDS; i++)
        prog_q[i] <= 32'h0;
    end
    else if (REG_WR && !REG_ADDR[7] && (REG_ADDR[1:0] == 2'h0)
      && (REG_ADDR[6:2] <= `FPS_LAST_WORD))
      prog_q[REG_ADDR[6:2]] <= REG_WDATA;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      key_q <= 16'h0;
      sel_a_q <= 8'h0;
      sel_b_q <= 8'h0;
      pump_q <= 8'h0;
      ena_q <= 2'h0;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        `FPS_OFF_KEY: key_q <= REG_WDATA[15:0];
        `FPS_OFF_TIME:
        begin
          sel_a_q <= REG_WDATA[7:0];
          sel_b_q <= REG_WDATA[15:8];
        end
        `FPS_OFF_CP: pump_q <= REG_WDATA[7:0];
        `FPS_OFF_ENA: ena_q <= REG_WDATA[1:0];
        default: ;
      endcase
    end
  end

  // Command stays set while busy so software can poll it
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      cmd_q <= `FPS_CMD_IDLE;
    else if (start_pgm)
      cmd_q <= `FPS_CMD_PGM;
    else if (start_rd)
      cmd_q <= `FPS_CMD_RD;
    else if (pgm_fin || rd_fin)
      cmd_q <= `FPS_CMD_IDLE;
  end

  // Sequencer: burn scans all bits, reload reads all words
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= fps_pkg::FPS_IDLE;
      req_q <= '0;
      idx_q <= 10'h0;
      rword_q <= 5'h0;
    end
    else
    begin
      unique case (state_q)
        fps_pkg::FPS_IDLE:
        begin
          idx_q <= 10'h0;
          rword_q <= 5'h0;
          if (start_pgm)
            state_q <= fps_pkg::FPS_P_SCAN;
          else if (start_rd)
            state_q <= fps_pkg::FPS_R_ISSUE;
        end
        fps_pkg::FPS_P_SCAN:
        begin
          if (burn_here)
          begin
            req_q.pgm <= 1'b1;
            req_q.addr <= idx_q;
            state_q <= fps_pkg::FPS_P_PULSE;
          end
          else if (pgm_fin)
            state_q <= fps_pkg::FPS_IDLE;
          else
            idx_q <= idx_q + 10'h1;
        end
        fps_pkg::FPS_P_PULSE:
        begin
          if (tmr_expire)
          begin
            req_q.pgm <= 1'b0;
            state_q <= fps_pkg::FPS_P_GAP;
          end
        end
        fps_pkg::FPS_P_GAP:
        begin
          if (pgm_fin)
            state_q <= fps_pkg::FPS_IDLE;
          else if (tmr_expire)
          begin
            idx_q <= idx_q + 10'h1;
            state_q <= fps_pkg::FPS_P_SCAN;
          end
        end
        fps_pkg::FPS_R_ISSUE:
        begin
          req_q.rd <= 1'b1;
          req_q.addr <= {rword_q, 5'h00};
          state_q <= fps_pkg::FPS_R_HOLD;
        end
        fps_pkg::FPS_R_HOLD:
        begin
          req_q.rd <= 1'b0;
          state_q <= fps_pkg::FPS_R_CAP;
        end
        fps_pkg::FPS_R_CAP:
        begin
          rword_q <= rword_q + 5'h1;
          state_q <= rd_fin ? fps_pkg::FPS_IDLE : fps_pkg::FPS_R_ISSUE;
        end
      endcase
    end
  end

  // Fuse image as last reloaded; protection is judged from it
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < `FPS_NWORDS; i++)
        shadow_q[i] <= 32'h0;
    end
    else if (state_q == fps_pkg::FPS_R_CAP)
      shadow_q[rword_q] <= FUSE_RDATA;
  end

  // Set beats clear in the same cycle
  always_comb
  begin
    raw_d = raw_q;
    if (REG_WR && (REG_ADDR == `FPS_OFF_CLR))
      raw_d = raw_q & ~REG_WDATA[1:0];
    if (pgm_fin)
      raw_d[`FPS_EV_PGM] = 1'b1;
    if (rd_fin)
      raw_d[`FPS_EV_RD] = 1'b1;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      raw_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      raw_q <= raw_d;
      irq_q <= |(raw_q & ena_q);
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      rdata_q <= 32'h0;
    else if (!REG_RD)
      rdata_q <= 32'h0;
    else if (!REG_ADDR[7])
      rdata_q <= ((REG_ADDR[1:0] == 2'h0)
        && (REG_ADDR[6:2] <= `FPS_LAST_WORD))
        ? prog_q[REG_ADDR[6:2]] : 32'h0;
    else
    begin
      unique case (REG_ADDR)
        `FPS_OFF_KEY: rdata_q <= {16'h0, key_q};
        `FPS_OFF_CMD: rdata_q <= {30'h0, cmd_q};
        `FPS_OFF_TIME: rdata_q <= {16'h0, sel_b_q, sel_a_q};
        `FPS_OFF_CP: rdata_q <= {24'h0, pump_q};
        `FPS_OFF_RAW: rdata_q <= {30'h0, raw_q};
        `FPS_OFF_ENA: rdata_q <= {30'h0, ena_q};
        `FPS_OFF_ST: rdata_q <= {30'h0, raw_q & ena_q};
        `FPS_OFF_CODE: rdata_q <= {20'h0, scheme_width(code_eff),
          hold, code_eff};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign REG_RDATA = rdata_q;
  assign FUSE_REQ = req_q;
  assign FUSE_PUMP_DIV = pump_q;
  assign IRQ = irq_q;
  sequence s_pgm_end;
    (cmd_q == `FPS_CMD_PGM) ##1 (cmd_q == `FPS_CMD_IDLE);
  endsequence
  sequence s_rd_end;
    (cmd_q == `FPS_CMD_RD) ##1 (cmd_q == `FPS_CMD_IDLE);
  endsequence
  property p_pgm_start;
    start_pgm |=> (cmd_q == `FPS_CMD_PGM) && req_q.rd == 1'b0;
  endproperty
  a_pgm_start: assert property (p_pgm_start)
    else $error("burn command not taken");
  property p_bad_key;
    (wr_cmd && (state_q == fps_pkg::FPS_IDLE)
      && !((REG_WDATA == {30'h0, `FPS_CMD_PGM}) && (key_q == `FPS_KEY_PGM))
      && !((REG_WDATA == {30'h0, `FPS_CMD_RD}) && (key_q == `FPS_KEY_RD)))
      |=> (cmd_q == `FPS_CMD_IDLE) && (state_q == fps_pkg::FPS_IDLE);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("command taken without key");
  property p_pgm_done;
    s_pgm_end |-> raw_q[`FPS_EV_PGM] && (state_q == fps_pkg::FPS_IDLE);
  endproperty
  a_pgm_done: assert property (p_pgm_done)
    else $error("burn end without program-done event");
  property p_rd_done;
    s_rd_end |-> raw_q[`FPS_EV_RD] && (state_q == fps_pkg::FPS_IDLE);
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("reload end without read-done event");
  property p_clear;
    (REG_WR && (REG_ADDR == `FPS_OFF_CLR) && REG_WDATA[`FPS_EV_PGM]
      && !pgm_fin) |=> !raw_q[`FPS_EV_PGM];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_irq;
    ##1 (IRQ == |($past(raw_q) & $past(ena_q)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_status;
    (REG_RD && (REG_ADDR == `FPS_OFF_ST))
      |=> REG_RDATA == {30'h0, $past(raw_q) & $past(ena_q)};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_no_reburn;
    $rose(req_q.pgm) |-> !shadow_q[req_q.addr[9:5]][req_q.addr[4:0]]
      && !shadow_q[`FPS_W_WRDIS][guard_bit(req_q.addr[9:5])];
  endproperty
  a_no_reburn: assert property (p_no_reburn)
    else $error("burn of burned or protected bit");
  property p_hold_rsv;
    req_q.pgm |-> !reserved(req_q.addr[9:5], hold)
      && (!hold || code_eff == `FPS_CODE_34);
  endproperty
  a_hold_rsv: assert property (p_hold_rsv)
    else $error("reserved key words burned under hold");
endmodule // fps_top

/* tb/fps_fuse_model.sv */
`timescale 1ns/10ps
// Behavioural fuse array; a bit can only ever blow
module fps_fuse_model (
  input wire logic clk,
  input wire fps_pkg::fps_fuse_req_t req,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:30];
  logic [31:0] word_q;
  logic show_q;
  logic pgm_q;
  int n_burn;
  int n_hi;
  initial
  begin
    foreach (mem[i])
      mem[i] = 32'h0;
    word_q = 32'h0;
    show_q = 1'b0;
    pgm_q = 1'b0;
    n_burn = 0;
    n_hi = 0;
  end
  always @(posedge clk)
  begin
    if (req.pgm)
      mem[req.addr[9:5]][req.addr[4:0]] <= 1'b1;
    if (req.pgm)
      n_hi <= n_hi + 1;
    if (req.pgm && !pgm_q)
      n_burn <= n_burn + 1;
    pgm_q <= req.pgm;
    show_q <= req.rd;
    if (req.rd)
      word_q <= mem[req.addr[9:5]];
  end
  // Stale word inverted so a late capture cannot pass by luck
  assign rdata = show_q ? word_q : ~word_q;
endmodule // fps_fuse_model

/* tb/fuse_program_sequencer_tb.sv */
`timescale 1ns/10ps
`include "fps_cfg.svh"
module fuse_program_sequencer_tb;
  logic clk_sys;
  logic nrst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  fps_pkg::fps_fuse_req_t fuse_req;
  logic [31:0] fuse_rdata;
  logic [7:0] pump_div;
  logic irq;
  logic [31:0] rv;
  int n_errors;
  int n_tests;

  fps_top u_dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FUSE_REQ(fuse_req), .FUSE_RDATA(fuse_rdata),
    .FUSE_PUMP_DIV(pump_div), .IRQ(irq)
  );
  fps_fuse_model u_fuse (.clk(clk_sys), .req(fuse_req), .rdata(fuse_rdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    if (nm != "")
      chk(nm, rv, e);
  endtask

  // Polls the command register; a burn scan needs about a thousand cycles
  task automatic op(input logic [15:0] k, input logic [1:0] c);
    int i;
    i = 0;
    wr(`FPS_OFF_KEY, {16'h0, k});
    wr(`FPS_OFF_CMD, {30'h0, c});
    rdc("cmd busy", `FPS_OFF_CMD, {30'h0, c});
    while (rv !== 32'h0 && i < 3000)
    begin
      rdc("", `FPS_OFF_CMD, 32'h0);
      i++;
    end
    chk("cmd done", rv, 32'h0);
  endtask

  task automatic burn_reload;
    op(`FPS_KEY_PGM, `FPS_CMD_PGM);
    op(`FPS_KEY_RD, `FPS_CMD_RD);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    print_verdict;
  end

  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc("cmd rst", `FPS_OFF_CMD, 32'h0);
    rdc("raw rst", `FPS_OFF_RAW, 32'h0);
    rdc("code rst", `FPS_OFF_CODE, 32'h800);
    rdc("unmapped", 8'hFC, 32'h0);
    wr(8'h78, 32'hA5A5_5A5A);
    rdc("word30", 8'h78, 32'hA5A5_5A5A);
    wr(8'h78, 32'h0);
    wr(`FPS_OFF_TIME, 32'h0000_0203);
    wr(`FPS_OFF_CP, 32'h0000_0050);
    #1 chk("pump", {24'h0, pump_div}, 32'h50);
    // Swapped keys must leave the engine idle
    wr(`FPS_OFF_KEY, {16'h0, `FPS_KEY_RD});
    wr(`FPS_OFF_CMD, 32'h2);
    rdc("bad pgm", `FPS_OFF_CMD, 32'h0);
    wr(`FPS_OFF_KEY, {16'h0, `FPS_KEY_PGM});
    wr(`FPS_OFF_CMD, 32'h1);
    rdc("bad rd", `FPS_OFF_CMD, 32'h0);
    wr(8'h04, 32'h0000_00A5);
    wr(8'h1C, 32'h8000_0001);
    op(`FPS_KEY_PGM, `FPS_CMD_PGM);
    chk("bursts1", 32'(u_fuse.n_burn), 32'h6);
    chk("pulse", 32'(u_fuse.n_hi), 32'h12);
    chk("w1", u_fuse.mem[1], 32'hA5);
    chk("w7", u_fuse.mem[7], 32'h8000_0001);
    rdc("raw pgm", `FPS_OFF_RAW, 32'h2);
    rdc("st off", `FPS_OFF_ST, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
    op(`FPS_KEY_RD, `FPS_CMD_RD);
    rdc("raw both", `FPS_OFF_RAW, 32'h3);
    wr(`FPS_OFF_CLR, 32'h1);
    rdc("raw clr0", `FPS_OFF_RAW, 32'h2);
    wr(`FPS_OFF_ENA, 32'h2);
    rdc("st on", `FPS_OFF_ST, 32'h2);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(`FPS_OFF_CLR, 32'h2);
    rdc("raw clr1", `FPS_OFF_RAW, 32'h0);
    chk("irq clr", {31'h0, irq}, 32'h0);
    wr(`FPS_OFF_ENA, 32'h0);
    wr(8'h1C, 32'h0);
    // Already blown bits of word 1 must not be pulsed again
    wr(8'h04, 32'h0000_01A5);
    wr(8'h18, 32'h0000_0002);
    burn_reload();
    chk("bursts2", 32'(u_fuse.n_burn), 32'h8);
    chk("w1 again", u_fuse.mem[1], 32'h1A5);
    rdc("code rep", `FPS_OFF_CODE, 32'h402);
    wr(8'h04, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h0C, 32'h0000_4000);
    wr(8'h00, 32'h0000_0080);
    burn_reload();
    chk("bursts3", 32'(u_fuse.n_burn), 32'hA);
    rdc("code hold", `FPS_OFF_CODE, 32'h605);
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h6C, 32'h0000_0001);
    wr(8'h3C, 32'h0000_0001);
    burn_reload();
    chk("bursts4", 32'(u_fuse.n_burn), 32'hB);
    chk("w7 prot", u_fuse.mem[7], 32'h8000_0001);
    chk("w27 rsv", u_fuse.mem[27], 32'h0);
    chk("w15", u_fuse.mem[15], 32'h1);
    print_verdict;
  end
endmodule // fuse_program_sequencer_tb
